// ### rtl/memory_protection_checker.v
// memory protection checker for data and code accesses
// ==========================================================
// Summary of operation
// R1: two complete protection sets, 0 and 1, each with code and data ranges.
// R2: protection set select field of program status word picks active set.
// R3: each data set has four ranges, each with its own mode.
// R4: each code set has two ranges, each with its own mode.
// R5: every range has lower and upper bound plus one mode register.
// R6: read and write kinds allowed per range by programmed permissions.
// R7: a violating access raises a trap toward the trap handler routine.
// R8: a violation also asserts an indication toward the debug unit.
// R9: inside a range means lower <= address < upper.
// R10: access hitting no enabled range is illegal, same trap.
`timescale 1ns/1ns
`default_nettype none
`include "mem_protect_consts.vh"
module memory_protection_checker (
   input  wire                  core_clk,
   input  wire                  rst_n,
   input  wire                  protection_set_select,
   input  wire                  cfg_we,
   input  wire                  cfg_set,
   input  wire                  cfg_kind,
   input  wire [`MP_SEL_W-1:0]  cfg_index,
   input  wire [`MP_CFG_W-1:0]  cfg_field,
   input  wire [`MP_ADDR_W-1:0] cfg_wdata,
   input  wire                  data_valid,
   input  wire [`MP_ADDR_W-1:0] data_addr,
   input  wire                  data_read,
   input  wire                  data_write,
   input  wire                  fetch_valid,
   input  wire [`MP_ADDR_W-1:0] fetch_addr,
   output reg                   data_trap,
   output reg                   code_trap,
   output reg  [`MP_ADDR_W-1:0] trap_addr,
   output reg                   debug_violation
);
   localparam ND = `MP_NUM_SETS * `MP_DATA_RANGES;
   localparam NC = `MP_NUM_SETS * `MP_CODE_RANGES;

   // ==========================================================
   // protection registers
   reg [`MP_ADDR_W-1:0] d_lower_reg [0:ND-1]; // R1 R3 R5
   reg [`MP_ADDR_W-1:0] d_upper_reg [0:ND-1];
   reg [`MP_MODE_W-1:0] d_mode_reg  [0:ND-1];
   reg [`MP_ADDR_W-1:0] c_lower_reg [0:NC-1]; // R1 R4 R5
   reg [`MP_ADDR_W-1:0] c_upper_reg [0:NC-1];
   reg [`MP_MODE_W-1:0] c_mode_reg  [0:NC-1];

   function [2:0] d_slot;
      input set;
      input [`MP_SEL_W-1:0] idx;
      d_slot = {set, idx};
   endfunction

   function [1:0] c_slot;
      input set;
      input [`MP_SEL_W-1:0] idx;
      c_slot = {set, idx[0]};
   endfunction

   integer i;
   always @(posedge core_clk) begin
      if (!rst_n) begin
         for (i = 0; i < ND; i = i + 1) begin
            d_lower_reg[i] <= `MP_BOUND_RESET;
            d_upper_reg[i] <= `MP_BOUND_RESET;
            d_mode_reg[i]  <= `MP_MODE_RESET;
         end
         for (i = 0; i < NC; i = i + 1) begin
            c_lower_reg[i] <= `MP_BOUND_RESET;
            c_upper_reg[i] <= `MP_BOUND_RESET;
            c_mode_reg[i]  <= `MP_MODE_RESET;
         end
      end else if (cfg_we) begin
         if (cfg_kind == `MP_KIND_DATA) begin
            case (cfg_field)
               `MP_CFG_LOWER: d_lower_reg[d_slot(cfg_set, cfg_index)] <= cfg_wdata;
               `MP_CFG_UPPER: d_upper_reg[d_slot(cfg_set, cfg_index)] <= cfg_wdata;
               `MP_CFG_MODE:  d_mode_reg[d_slot(cfg_set, cfg_index)]  <=
                                 cfg_wdata[`MP_MODE_W-1:0];
               default: ;
            endcase
         end else if (cfg_index < `MP_CODE_RANGES) begin
            case (cfg_field)
               `MP_CFG_LOWER: c_lower_reg[c_slot(cfg_set, cfg_index)] <= cfg_wdata;
               `MP_CFG_UPPER: c_upper_reg[c_slot(cfg_set, cfg_index)] <= cfg_wdata;
               `MP_CFG_MODE:  c_mode_reg[c_slot(cfg_set, cfg_index)]  <=
                                 cfg_wdata[`MP_MODE_W-1:0];
               default: ;
            endcase
         end
      end
   end

   // ==========================================================
   // range checks for the active set
   wire [`MP_MODE_W-1:0] d_need = {data_write, data_read};
   wire [`MP_MODE_W-1:0] c_need = {1'h0, 1'h1};
   wire [`MP_DATA_RANGES-1:0] d_allow;
   wire [`MP_CODE_RANGES-1:0] c_allow;

   genvar g;
   generate
      for (g = 0; g < `MP_DATA_RANGES; g = g + 1) begin : g_data
         range_match u_match (
            .addr  (data_addr),
            .lower (d_lower_reg[{protection_set_select, g[1:0]}]), // R2
            .upper (d_upper_reg[{protection_set_select, g[1:0]}]),
            .mode  (d_mode_reg[{protection_set_select, g[1:0]}]),
            .need  (d_need),
            .hit   (),
            .allow (d_allow[g])
         );
      end
      for (g = 0; g < `MP_CODE_RANGES; g = g + 1) begin : g_code
         range_match u_match (
            .addr  (fetch_addr),
            .lower (c_lower_reg[{protection_set_select, g[0]}]), // R2
            .upper (c_upper_reg[{protection_set_select, g[0]}]),
            .mode  (c_mode_reg[{protection_set_select, g[0]}]),
            .need  (c_need),
            .hit   (),
            .allow (c_allow[g])
         );
      end
   endgenerate

   // no permitting range means violation
   wire d_bad = data_valid && (data_read || data_write) && !(|d_allow); // R10 R6
   wire c_bad = fetch_valid && !(|c_allow); // R10

   // ==========================================================
   // trap and debug outputs
   always @(posedge core_clk) begin
      if (!rst_n) begin
         data_trap       <= 1'h0;
         code_trap       <= 1'h0;
         trap_addr       <= `MP_BOUND_RESET;
         debug_violation <= 1'h0;
      end else begin
         data_trap       <= d_bad; // R7
         code_trap       <= c_bad; // R7
         debug_violation <= d_bad || c_bad; // R8
         if (d_bad)
            trap_addr <= data_addr;
         else if (c_bad)
            trap_addr <= fetch_addr;
      end
   end
endmodule // memory_protection_checker
`default_nettype wire

// ### rtl/mem_protect_consts.vh
// constants for the memory protection checker
`ifndef MEM_PROTECT_CONSTS_VH
`define MEM_PROTECT_CONSTS_VH
`define MP_ADDR_W        32
`define MP_NUM_SETS      2
`define MP_DATA_RANGES   4
`define MP_CODE_RANGES   2
`define MP_MODE_W        2
`define MP_MODE_RD_BIT   0
`define MP_MODE_WR_BIT   1
`define MP_MODE_EX_BIT   0
`define MP_SEL_W         2
`define MP_CFG_W         2
`define MP_CFG_LOWER     2'h0
`define MP_CFG_UPPER     2'h1
`define MP_CFG_MODE      2'h2
`define MP_MODE_RESET    2'h0
`define MP_BOUND_RESET   32'h00000000
`define MP_KIND_DATA     1'h0
`define MP_KIND_CODE     1'h1
`endif

// ### rtl/range_match.v
// one protection range: bound compare and permission check
`timescale 1ns/1ns
`default_nettype none
`include "mem_protect_consts.vh"
module range_match (
   input  wire [`MP_ADDR_W-1:0] addr,
   input  wire [`MP_ADDR_W-1:0] lower,
   input  wire [`MP_ADDR_W-1:0] upper,
   input  wire [`MP_MODE_W-1:0] mode,
   input  wire [`MP_MODE_W-1:0] need,
   output wire                  hit,
   output wire                  allow
);
   // inside when lower <= addr < upper
   assign hit   = (addr >= lower) && (addr < upper); // R9
   // every needed permission bit must be granted
   assign allow = hit && ((mode & need) == need) && (need != {`MP_MODE_W{1'b0}}); // R6
endmodule // range_match
`default_nettype wire

// ### verification/mpc_sva.sv
// assertions on the protection checker ports
`timescale 1ns/1ns
`default_nettype none
module mpc_sva (
   input wire        core_clk,
   input wire        rst_n,
   input wire        data_valid,
   input wire        data_read,
   input wire        data_write,
   input wire        fetch_valid,
   input wire [31:0] data_addr,
   input wire [31:0] fetch_addr,
   input wire        data_trap,
   input wire        code_trap,
   input wire [31:0] trap_addr,
   input wire        debug_violation
);
default clocking @(posedge core_clk); endclocking
default disable iff (!rst_n);
chk_debug_or: assert property (debug_violation == (data_trap | code_trap))
   else $error("debug");
chk_data_cause: assert property (!data_valid || !(data_read | data_write) |=> !data_trap)
   else $error("data cause");
chk_code_cause: assert property (!fetch_valid |=> !code_trap)
   else $error("code cause");
chk_data_addr: assert property (data_trap |-> trap_addr == $past(data_addr))
   else $error("data addr");
chk_code_addr: assert property (code_trap && !data_trap |-> trap_addr == $past(fetch_addr))
   else $error("code addr");
chk_addr_hold: assert property (!debug_violation |-> $stable(trap_addr))
   else $error("addr hold");
chk_reset_quiet: assert property ($rose(rst_n) |-> !data_trap && !code_trap)
   else $error("reset");
chk_debug_cause: assert property (!data_valid && !fetch_valid |=> !debug_violation)
   else $error("debug cause");
endmodule // mpc_sva
bind memory_protection_checker mpc_sva u_mpc_sva (.core_clk, .rst_n, .data_valid, .data_read,
   .data_write, .fetch_valid, .data_addr, .fetch_addr, .data_trap, .code_trap, .trap_addr,
   .debug_violation);
`default_nettype wire

// ### verification/core_access_model.sv
// core-side model driving data and fetch requests
`timescale 1ns/1ns
`default_nettype none
module core_access_model (
   input  wire        core_clk,
   output reg         protection_set_select,
   output reg         data_valid,
   output reg         data_read,
   output reg         data_write,
   output reg         fetch_valid,
   output reg  [31:0] data_addr,
   output reg  [31:0] fetch_addr
);
initial {protection_set_select, data_valid, data_read, data_write, fetch_valid} = 5'h00;
initial {data_addr, fetch_addr} = 64'h0;
// one access per call; released addresses toggle
task drive(input [4:0] c, input [31:0] d, input [31:0] f);
   @(negedge core_clk);
   {protection_set_select, data_valid, data_read, data_write, fetch_valid} = c;
   data_addr = c[3] ? d : ~data_addr;
   fetch_addr = c[0] ? f : ~fetch_addr;
endtask
endmodule // core_access_model
`default_nettype wire

// ### verification/memory_protection_checker_test.sv
// self-checking bench for the protection checker
`timescale 1ns/1ns
`default_nettype none
module memory_protection_checker_test;
reg          core_clk = 1'h0;
reg          rst_n = 1'h0;
reg          cfg_we = 1'h0;
reg          cfg_set = 1'h0;
reg          cfg_kind = 1'h0;
reg  [1:0]   cfg_index = 2'h0;
reg  [1:0]   cfg_field = 2'h0;
reg  [31:0]  cfg_wdata = 32'h0;
reg  [31:0]  seed = 32'hB41A;
reg  [31:0]  a;
reg  [31:0]  e = 32'h0;
reg          b;
wire         protection_set_select, data_valid, data_read, data_write, fetch_valid;
wire         data_trap, code_trap, debug_violation;
wire [31:0]  data_addr, fetch_addr, trap_addr;
logic [65:0] q[$];
integer      errors = 0, n_checks = 0, cyc = 0, i;
core_access_model u_core_access_model (.core_clk, .protection_set_select, .data_valid,
   .data_read, .data_write, .fetch_valid, .data_addr, .fetch_addr);
memory_protection_checker u_memory_protection_checker (.core_clk, .rst_n,
   .protection_set_select, .cfg_we, .cfg_set, .cfg_kind, .cfg_index, .cfg_field, .cfg_wdata,
   .data_valid, .data_addr, .data_read, .data_write, .fetch_valid, .fetch_addr, .data_trap,
   .code_trap, .trap_addr, .debug_violation);
always #5 core_clk = ~core_clk;
always @(posedge core_clk) cyc <= cyc + 1;
// ==========================================================
// tasks
task rng(input [3:0] t, input [31:0] lo, input [31:0] hi, input [1:0] m);
   for (i = 0; i < 3; i = i + 1) begin
      @(negedge core_clk);
      {cfg_we, cfg_set, cfg_kind, cfg_index} = {1'h1, t};
      cfg_field = i[1:0];
      cfg_wdata = (i == 0) ? lo : (i == 1) ? hi : {30'h0, m};
      @(negedge core_clk);
      cfg_we = 1'h0;
   end
endtask
// code bits: set, valid, read, write, fetch, data trap, code trap
task acc(input [6:0] c, input [31:0] d, input [31:0] f);
   u_core_access_model.drive(c[6:2], d, f);
   q.push_back({cyc + 1, c[1:0], c[1] ? d : f});
endtask
task finish_test;
   $display("checks %0d errors %0d", n_checks, errors);
   if (errors == 0 && n_checks > 0)
      $display("Result: passed");
   else
      $display("Result: failed");
   $finish;
endtask
// ==========================================================
// monitor
always @(negedge core_clk)
   while (q.size() && q[0][65:34] == cyc) begin
      n_checks = n_checks + 1;
      if (q[0][33] | q[0][32])
         e = q[0][31:0];
      if ({data_trap, code_trap, debug_violation, trap_addr} !== {q[0][33:32], |q[0][33:32], e}) begin
         errors = errors + 1;
         $display("MISMATCH t=%0t got %h exp %h", $time,
            {data_trap, code_trap, debug_violation, trap_addr}, {q[0][33:32], |q[0][33:32], e});
      end
      void'(q.pop_front());
   end
// ==========================================================
// main sequence
initial begin
   repeat (8) @(negedge core_clk);
   rst_n = 1'h1;
   acc(7'h3F, 32'h1000, 32'h5000);
   rng(4'h0, 32'h1000, 32'h2000, 2'h1);
   rng(4'h3, 32'h3000, 32'h4000, 2'h3);
   rng(4'h5, 32'h5000, 32'h6000, 2'h1);
   rng(4'h8, 32'h2000, 32'h3000, 2'h2);
   acc(7'h34, 32'h1000, 32'h5000);
   acc(7'h37, 32'h2000, 32'h4FFF);
   acc(7'h2A, 32'h1FFF, 32'h0);
   acc(7'h3A, 32'h1800, 32'h0);
   acc(7'h3D, 32'h3FFC, 32'h1000);
   acc(7'h20, 32'h0, 32'h0);
   acc(7'h68, 32'h2000, 32'h0);
   acc(7'h77, 32'h1000, 32'h5000);
   for (i = 0; i < 20; i = i + 1) begin
      a = $random(seed) & 32'h3FFF;
      b = !((a >= 32'h1000 && a < 32'h2000) || (a >= 32'h3000 && a < 32'h4000));
      acc({5'h0C, b, 1'h0}, a, 32'h0);
   end
   acc(7'h00, 32'h0, 32'h0);
   repeat (3) @(negedge core_clk);
   rst_n = 1'h0;
   repeat (2) @(negedge core_clk);
   rst_n = 1'h1;
   acc(7'h3F, 32'h1800, 32'h5000);
   repeat (4) @(negedge core_clk);
   if (q.size()) begin
      errors = errors + 1;
      $display("MISMATCH t=%0t got %h exp %h", $time, q.size(), 32'h0);
   end
   finish_test;
end
endmodule // memory_protection_checker_test
`default_nettype wire
